// [hdl/data_trace_params.svh]
// Offsets, field positions, reset values and codes of the data trace block.
`ifndef DATA_TRACE_PARAMS_SVH
`define DATA_TRACE_PARAMS_SVH
`define OFS_CONTROL      12'h000
`define OFS_START_CH0    12'h004
`define OFS_END_CH0      12'h008
`define OFS_START_CH1    12'h00c
`define OFS_END_CH1      12'h010
`define OFS_TRACE_CFG    12'h014
`define OFS_STATUS       12'h018
`define CTL_TYPE0_HI     31
`define CTL_TYPE0_LO     30
`define CTL_TYPE1_HI     29
`define CTL_TYPE1_LO     28
`define CTL_WP1_BIT      1
`define CTL_WP0_BIT      0
`define CTL_WMASK        32'hf000_0003
`define CFG_ENABLE_BIT   0
`define CFG_EVTI_SYNC    1
`define CFG_WMASK        32'h0000_0003
`define REG_RESET        32'h0000_0000
`define TC_READ          6'h06
`define TC_READ_SYNC     6'h0e
`define TC_WRITE         6'h05
`define TC_WRITE_SYNC    6'h0d
`define TC_BITOP         6'h3a
`define TC_BITOP_SYNC    6'h3b
`define TC_ERROR         6'h08
`define ECODE_OVERRUN    5'h02
`define TC_WATCHPOINT    6'h38
`define SYNC_PERIOD      8'hff
`endif

// [hdl/data_trace_pkg.sv]
// Types shared by the data trace files.
package data_trace_pkg;
    typedef enum logic [1:0] {
        acc_read  = 2'b00,
        acc_write = 2'b01,
        acc_bitop = 2'b10
    } access_kind_type;
    typedef struct packed {
        logic            valid;
        access_kind_type kind;
        logic [31:0]     addr;
        logic [31:0]     data;
        logic [1:0]      size_code;
        logic [4:0]      bit_index;
        logic [1:0]      bit_op;
    } cpu_access_type;
    typedef struct packed {
        logic        valid;
        logic [5:0]  tcode;
        logic [31:0] addr;
        logic [31:0] data;
        logic [1:0]  size_code;
        logic [4:0]  bit_index;
        logic [1:0]  bit_op;
        logic [4:0]  ecode;
    } trace_msg_type;
    typedef struct packed {
        logic [1:0]  match;
    } match_type;
endpackage : data_trace_pkg

// [hdl/range_match.sv]
// Inclusive address range comparator for one trace channel.
`timescale 1ns/100ps
module range_match (
    // Range and access address.
    input  wire logic [31:0] start_addr,
    input  wire logic [31:0] end_addr,
    input  wire logic [31:0] addr,
    // Match result.
    output logic             hit
);
    // Empty when start exceeds end; single location when equal.
    assign hit = (start_addr <= end_addr) && (addr >= start_addr)
               && (addr <= end_addr);
endmodule : range_match

// [hdl/sync_counter.sv]
// Counter of compressed messages since the last synchronising one.
`timescale 1ns/100ps
`include "data_trace_params.svh"
module sync_counter (
    // Clock and reset.
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Message events.
    input  wire logic       sent_plain,
    input  wire logic       sent_sync,
    // Expiry level.
    output logic            expired
);
    logic [7:0] count_r;
    logic [7:0] count_nxt;
    always_comb begin
        count_nxt = count_r;
        if (sent_sync) begin
            count_nxt = 8'h00;
        end else if (sent_plain && count_r != `SYNC_PERIOD) begin
            count_nxt = count_r + 8'h01;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= 8'h00;
        end else begin
            count_r <= count_nxt;
        end
    end
    assign expired = (count_r == `SYNC_PERIOD);
endmodule : sync_counter

// [hdl/data_trace.sv]
// Data trace channels, sync tracking and message builder with APB access.
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/100ps
`include "data_trace_params.svh"
//Function
//- Pending sync turns read into sync read
//- Reset exit makes sync pending
//- Enabling trace while running forces sync
//- Power-down exit makes sync pending
//- Event pin with select forces sync
//- Overrun sends error before next sync
//- After 255 compressed messages force sync
//- First read after debug exit syncs
//- Sync read: data, full address, size, 14
//- Bit operations in range make messages
//- Compressed bit op: relative address, 58
//- Bit op under sync conditions uses 59
//- Channel 0 type bits 31:30
//- Channel 1 type bits 29:28
//- Control bits 1:0 enable watchpoints
//- Inclusive start-to-end range per channel
//- Equal start and end: single location
//- Start above end never matches
//- Trace messages only while trace enable set; watchpoint messages and the sync after an error regardless
//- Enabled watchpoint emits message per match
//- Compressed read: relative address, tcode 6
module data_trace
    import data_trace_pkg::*;
(
    // Clock and reset.
    input  wire logic           pclk,
    input  wire logic           presetn,
    // APB slave.
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [11:0]    paddr,
    input  wire logic [31:0]    pwdata,
    output logic      [31:0]    prdata,
    output logic                pready,
    output logic                pslverr,
    // Processor status and events.
    input  wire cpu_access_type cpu_access,
    input  wire logic           cpu_running,
    input  wire logic           powerdown_exit,
    input  wire logic           debug_exit,
    input  wire logic           event_in,
    input  wire logic           overrun,
    input  wire logic           wp_trace_on,
    input  wire logic           wp_trace_off,
    // Trace output.
    output trace_msg_type       trace_msg,
    output logic                watchpoint_msg,
    output logic      [1:0]     watchpoint_ch
);
    typedef struct packed {
        logic [31:0]   control;
        logic [31:0]   start0;
        logic [31:0]   end0;
        logic [31:0]   start1;
        logic [31:0]   end1;
        logic [1:0]    cfg;
        logic          sync_pend;
        logic          overrun_pend;
        logic          err_sent;
        logic [31:0]   prev_addr;
        cpu_access_type held;
        logic          held_sync;
        trace_msg_type msg;
        logic          wp_msg;
        logic [1:0]    wp_ch;
        logic [31:0]   rdata;
        logic          ready;
        logic          slverr;
    } state_type;

    state_type st_r;
    state_type st_nxt;
    logic      hit0;
    logic      hit1;
    logic      expired;
    logic      sent_plain;
    logic      sent_sync;

    range_match u_match0 (
        .start_addr (st_r.start0),
        .end_addr   (st_r.end0),
        .addr       (cpu_access.addr),
        .hit        (hit0)
    );
    range_match u_match1 (
        .start_addr (st_r.start1),
        .end_addr   (st_r.end1),
        .addr       (cpu_access.addr),
        .hit        (hit1)
    );
    sync_counter u_count (
        .pclk       (pclk),
        .presetn    (presetn),
        .sent_plain (sent_plain),
        .sent_sync  (sent_sync),
        .expired    (expired)
    );

    // Decides if a channel traces this kind of access.
    function automatic logic kind_on(input logic [1:0] rw,
                                     input access_kind_type k);
        kind_on = (k == acc_read) ? rw[0] : rw[1];
    endfunction : kind_on

    logic [1:0] type0;
    logic [1:0] type1;
    logic       trace_hit;
    logic       acc_now;
    logic       bus_acc;
    assign type0 = st_r.control[`CTL_TYPE0_HI:`CTL_TYPE0_LO];
    assign type1 = st_r.control[`CTL_TYPE1_HI:`CTL_TYPE1_LO];
    assign trace_hit = (hit0 && kind_on(type0, cpu_access.kind))
                     || (hit1 && kind_on(type1, cpu_access.kind));
    assign acc_now = cpu_access.valid && trace_hit
                   && st_r.cfg[`CFG_ENABLE_BIT];
    assign bus_acc = psel && penable;
    assign sent_plain = st_nxt.msg.valid
        && (st_nxt.msg.tcode == `TC_READ || st_nxt.msg.tcode == `TC_WRITE
        || st_nxt.msg.tcode == `TC_BITOP);
    assign sent_sync = st_nxt.msg.valid
        && (st_nxt.msg.tcode == `TC_READ_SYNC
        || st_nxt.msg.tcode == `TC_WRITE_SYNC
        || st_nxt.msg.tcode == `TC_BITOP_SYNC);

    always_comb begin
        logic       sync_now;
        logic [1:0] cfg_w;
        sync_now = 1'b0;
        cfg_w = 2'b00;
        st_nxt = st_r;
        st_nxt.msg.valid = 1'b0;
        st_nxt.wp_msg = 1'b0;
        st_nxt.wp_ch = 2'b00;
        st_nxt.ready = 1'b0;
        st_nxt.slverr = 1'b0;
        // Register access; one wait state before pready.
        if (bus_acc && !st_r.ready) begin
            st_nxt.ready = 1'b1;
            st_nxt.rdata = 32'h0000_0000;
            case (paddr)
                `OFS_CONTROL: begin
                    st_nxt.rdata = st_r.control;
                    if (pwrite) begin
                        st_nxt.control = pwdata & `CTL_WMASK;
                    end
                end
                `OFS_START_CH0: begin
                    st_nxt.rdata = st_r.start0;
                    if (pwrite) begin
                        st_nxt.start0 = pwdata;
                    end
                end
                `OFS_END_CH0: begin
                    st_nxt.rdata = st_r.end0;
                    if (pwrite) begin
                        st_nxt.end0 = pwdata;
                    end
                end
                `OFS_START_CH1: begin
                    st_nxt.rdata = st_r.start1;
                    if (pwrite) begin
                        st_nxt.start1 = pwdata;
                    end
                end
                `OFS_END_CH1: begin
                    st_nxt.rdata = st_r.end1;
                    if (pwrite) begin
                        st_nxt.end1 = pwdata;
                    end
                end
                `OFS_TRACE_CFG: begin
                    st_nxt.rdata = {30'h0000_0000, st_r.cfg};
                    if (pwrite) begin
                        cfg_w = pwdata[1:0];
                        st_nxt.cfg = cfg_w;
                        if (cfg_w[`CFG_ENABLE_BIT]
                            && !st_r.cfg[`CFG_ENABLE_BIT]
                            && cpu_running) begin
                            st_nxt.sync_pend = 1'b1;
                        end
                    end
                end
                `OFS_STATUS: begin
                    st_nxt.rdata = {29'h0000_0000, expired,
                                    st_r.overrun_pend, st_r.sync_pend};
                end
                default: begin
                    st_nxt.slverr = 1'b1;
                end
            endcase
        end
        // Watchpoint triggers switch trace enable automatically.
        if (wp_trace_on && !st_nxt.cfg[`CFG_ENABLE_BIT]) begin
            st_nxt.cfg[`CFG_ENABLE_BIT] = 1'b1;
            if (cpu_running) begin
                st_nxt.sync_pend = 1'b1;
            end
        end else if (wp_trace_off) begin
            st_nxt.cfg[`CFG_ENABLE_BIT] = 1'b0;
        end
        // Sync causes; a new event wins over the clear below.
        if (st_r.err_sent) begin
            st_nxt.err_sent = 1'b0;
            st_nxt.msg.valid = 1'b1;
            st_nxt.msg.ecode = 5'h00;
            st_nxt.msg.data = st_r.held.data;
            st_nxt.msg.addr = st_r.held.addr;
            st_nxt.msg.size_code = st_r.held.size_code;
            st_nxt.msg.bit_index = st_r.held.bit_index;
            st_nxt.msg.bit_op = st_r.held.bit_op;
            case (st_r.held.kind)
                acc_read:  st_nxt.msg.tcode = `TC_READ_SYNC;
                acc_write: st_nxt.msg.tcode = `TC_WRITE_SYNC;
                default:   st_nxt.msg.tcode = `TC_BITOP_SYNC;
            endcase
            st_nxt.prev_addr = st_r.held.addr;
        end else if (acc_now) begin
            sync_now = st_r.sync_pend || st_r.overrun_pend
                     || expired;
            st_nxt.sync_pend = 1'b0;
            st_nxt.prev_addr = cpu_access.addr;
            if (st_r.overrun_pend) begin
                st_nxt.overrun_pend = 1'b0;
                st_nxt.err_sent = 1'b1;
                st_nxt.held = cpu_access;
                st_nxt.msg.valid = 1'b1;
                st_nxt.msg.tcode = `TC_ERROR;
                st_nxt.msg.ecode = `ECODE_OVERRUN;
            end else begin
                st_nxt.msg.valid = 1'b1;
                st_nxt.msg.ecode = 5'h00;
                st_nxt.msg.data = cpu_access.data;
                st_nxt.msg.size_code = cpu_access.size_code;
                st_nxt.msg.bit_index = cpu_access.bit_index;
                st_nxt.msg.bit_op = cpu_access.bit_op;
                st_nxt.msg.addr = sync_now ? cpu_access.addr
                    : (cpu_access.addr ^ st_r.prev_addr);
                case (cpu_access.kind)
                    acc_read: st_nxt.msg.tcode = sync_now
                        ? `TC_READ_SYNC : `TC_READ;
                    acc_write: st_nxt.msg.tcode = sync_now
                        ? `TC_WRITE_SYNC : `TC_WRITE;
                    default: st_nxt.msg.tcode = sync_now
                        ? `TC_BITOP_SYNC : `TC_BITOP;
                endcase
            end
        end
        if (powerdown_exit || debug_exit) begin
            st_nxt.sync_pend = 1'b1;
        end
        if (event_in && st_r.cfg[`CFG_EVTI_SYNC]) begin
            st_nxt.sync_pend = 1'b1;
        end
        if (overrun) begin
            st_nxt.overrun_pend = 1'b1;
        end
        // Watchpoint hits on any matching access to a channel whose control watchpoint bit is set.
        if (cpu_access.valid) begin
            st_nxt.wp_ch[0] = hit0 && st_r.control[`CTL_WP0_BIT];
            st_nxt.wp_ch[1] = hit1 && st_r.control[`CTL_WP1_BIT];
            st_nxt.wp_msg = st_nxt.wp_ch[0] || st_nxt.wp_ch[1];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
            st_r.sync_pend <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.rdata;
    assign pready = st_r.ready;
    assign pslverr = st_r.slverr;
    assign trace_msg = st_r.msg;
    assign watchpoint_msg = st_r.wp_msg;
    assign watchpoint_ch = st_r.wp_ch;

    a_read_sync: assert property (
        @(posedge pclk) disable iff (!presetn)
        acc_now && !st_r.overrun_pend && !st_r.err_sent && st_r.sync_pend
        && cpu_access.kind == acc_read
        |=> trace_msg.tcode == 6'h0e) else $error("no sync read");
    a_reset_sync: assert property (
        @(posedge pclk) $rose(presetn) |-> st_r.sync_pend)
        else $error("no sync after reset");
    a_error_first: assert property (
        @(posedge pclk) disable iff (!presetn)
        trace_msg.valid && trace_msg.tcode == 6'h08 |=> trace_msg.valid
        && trace_msg.tcode inside {6'h0e, 6'h0d, 6'h3b})
        else $error("error not followed by sync");
    a_bitop_plain: assert property (
        @(posedge pclk) disable iff (!presetn)
        acc_now && !st_r.sync_pend && !st_r.overrun_pend && !expired
        && !st_r.err_sent && cpu_access.kind == acc_bitop
        |=> trace_msg.tcode == 6'h3a) else $error("bad bitop code");
    a_enable_gate: assert property (
        @(posedge pclk) disable iff (!presetn)
        !st_r.cfg[0] && !st_r.err_sent |=> !trace_msg.valid)
        else $error("trace while disabled");
    a_wp_hit: assert property (
        @(posedge pclk) disable iff (!presetn)
        cpu_access.valid && hit0 && st_r.control[0] |=> watchpoint_msg)
        else $error("missing watchpoint");
    a_evti_sync: assert property (
        @(posedge pclk) disable iff (!presetn)
        event_in && st_r.cfg[1] && !acc_now |=> st_r.sync_pend)
        else $error("event sync lost");
    a_empty_range: assert property (
        @(posedge pclk) disable iff (!presetn)
        st_r.start0 > st_r.end0 |-> !hit0)
        else $error("empty range hit");
    a_bitop_sync: assert property (
        @(posedge pclk) disable iff (!presetn)
        acc_now && !st_r.overrun_pend && !st_r.err_sent && st_r.sync_pend
        && cpu_access.kind == acc_bitop
        |=> trace_msg.tcode == 6'h3b) else $error("no sync bitop");
    a_read_plain: assert property (
        @(posedge pclk) disable iff (!presetn)
        acc_now && !st_r.sync_pend && !st_r.overrun_pend && !expired
        && !st_r.err_sent && cpu_access.kind == acc_read
        |=> trace_msg.tcode == 6'h06 && trace_msg.addr
        == $past(cpu_access.addr ^ st_r.prev_addr)) else $error("bad read");
    a_count_sync: assert property (
        @(posedge pclk) disable iff (!presetn)
        acc_now && expired && !st_r.overrun_pend && !st_r.err_sent
        && cpu_access.kind == acc_read
        |=> trace_msg.tcode == 6'h0e) else $error("count sync missed");
    a_exit_sync: assert property (
        @(posedge pclk) disable iff (!presetn)
        powerdown_exit || debug_exit |=> st_r.sync_pend)
        else $error("exit sync lost");
    a_overrun_err: assert property (
        @(posedge pclk) disable iff (!presetn)
        acc_now && st_r.overrun_pend && !st_r.err_sent
        |=> trace_msg.valid && trace_msg.tcode == 6'h08
        && trace_msg.ecode == 5'h02) else $error("no overrun error");
    a_enable_sync: assert property (
        @(posedge pclk) disable iff (!presetn)
        bus_acc && !st_r.ready && pwrite && paddr == `OFS_TRACE_CFG
        && pwdata[0] && !st_r.cfg[0] && cpu_running |=> st_r.sync_pend)
        else $error("enable sync lost");
    c_sync_read: cover property (@(posedge pclk)
        trace_msg.valid && trace_msg.tcode == 6'h0e);
    c_bitop_sync: cover property (@(posedge pclk)
        trace_msg.valid && trace_msg.tcode == 6'h3b);
    c_error: cover property (@(posedge pclk)
        trace_msg.valid && trace_msg.tcode == 6'h08);
endmodule : data_trace

// [bench/trace_tool.sv]
// Debug tool model that collects trace messages and rebuilds addresses.
`timescale 1ns/100ps
module trace_tool
    import data_trace_pkg::*;
(
    // Clock.
    input  wire logic          pclk,
    // Trace stream from the device.
    input  wire trace_msg_type trace_msg,
    input  wire logic          watchpoint_msg,
    input  wire logic [1:0]    watchpoint_ch
);
    trace_msg_type msgs[$];
    logic [31:0]   addrs[$];
    logic [1:0]    wps[$];
    logic [31:0]   prev_addr = 32'h0000_0000;

    // Sync messages carry the full address, compressed ones only the changed bits.
    always @(posedge pclk) begin
        if (watchpoint_msg === 1'b1)
            wps.push_back(watchpoint_ch);
        if (trace_msg.valid === 1'b1) begin
            case (trace_msg.tcode)
                6'h0e, 6'h0d, 6'h3b: prev_addr = trace_msg.addr;
                6'h06, 6'h05, 6'h3a: begin
                    prev_addr = prev_addr ^ trace_msg.addr;
                end
                default: ;
            endcase
            msgs.push_back(trace_msg);
            addrs.push_back(trace_msg.tcode == 6'h08 ? 32'h0 : prev_addr);
        end
    end
endmodule : trace_tool

// [bench/tb_data_trace.sv]
// Self-checking testbench of the data trace block.
`timescale 1ns/100ps
module tb_data_trace;
    import data_trace_pkg::*;
    logic           pclk;
    logic           presetn;
    logic           psel;
    logic           penable;
    logic           pwrite;
    logic [11:0]    paddr;
    logic [31:0]    pwdata;
    logic [31:0]    prdata;
    logic           pready;
    logic           pslverr;
    cpu_access_type cpu_access;
    logic           cpu_running;
    logic [5:0]     evt;
    trace_msg_type  trace_msg;
    logic           watchpoint_msg;
    logic [1:0]     watchpoint_ch;
    logic [31:0]    rd;
    logic           err;
    int             fail_count;
    int             num_checks;

    data_trace u_data_trace (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cpu_access(cpu_access),
        .cpu_running(cpu_running), .powerdown_exit(evt[0]),
        .debug_exit(evt[1]), .event_in(evt[2]), .overrun(evt[3]),
        .wp_trace_on(evt[4]), .wp_trace_off(evt[5]), .trace_msg(trace_msg),
        .watchpoint_msg(watchpoint_msg), .watchpoint_ch(watchpoint_ch)
    );

    trace_tool u_trace_tool (
        .pclk(pclk), .trace_msg(trace_msg),
        .watchpoint_msg(watchpoint_msg), .watchpoint_ch(watchpoint_ch)
    );

    always #4 pclk = ~pclk;

    task automatic complete_run();
        if (fail_count == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer; the request holds until pready is seen high.
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fail_count++;
            complete_run();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rdchk

    // One processor access, then room for an error and a sync message.
    task automatic acc(input logic [1:0] k, input logic [31:0] a,
                       input logic [1:0] sz, input logic [6:0] bo);
        cpu_access <= '{1'b1, access_kind_type'(k), a, {24'h0, a[7:0]},
                        sz, bo[6:2], bo[1:0]};
        @(posedge pclk);
        cpu_access.valid <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : acc

    task automatic ev(input int i);
        evt[i] <= 1'b1;
        @(posedge pclk);
        evt <= 6'h00;
        @(posedge pclk);
    endtask : ev

    task automatic expect_msg(input logic [5:0] tc, input logic [31:0] a,
                              input logic [1:0] sz, input logic [6:0] bo);
        trace_msg_type m;
        logic [31:0]   fa;
        check(u_trace_tool.msgs.size() != 0, 1'b1);
        if (u_trace_tool.msgs.size() != 0) begin
            m = u_trace_tool.msgs.pop_front();
            fa = u_trace_tool.addrs.pop_front();
            check({m.tcode, fa}, {tc, a});
            if (tc == 6'h0e || tc == 6'h06)
                check({m.size_code, m.data}, {sz, 24'h0, a[7:0]});
            else if (tc == 6'h08)
                check(m.ecode, 5'h02);
            else
                check({m.bit_index, m.bit_op}, bo);
        end
    endtask : expect_msg

    task automatic none();
        check(u_trace_tool.msgs.size(), 0);
    endtask : none

    task automatic wpx(input logic [1:0] exp);
        check(u_trace_tool.wps.size(), 1);
        if (u_trace_tool.wps.size() == 1)
            check(u_trace_tool.wps.pop_front(), exp);
    endtask : wpx

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        cpu_access = '0;
        cpu_running = 1'b0;
        evt = 6'h00;
        fail_count = 0;
        num_checks = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int o = 0; o < 6; o++)
            rdchk(12'(o * 4), 32'h0);
        rdchk(12'h018, 32'h0000_0001);
        apb(1'b0, 12'h040, 32'h0);
        check(err, 1'b1);
        apb(1'b1, 12'h000, 32'hffff_ffff);
        rdchk(12'h000, 32'hf000_0003);
        apb(1'b1, 12'h000, 32'h4000_0000);
        apb(1'b1, 12'h004, 32'h0000_1000);
        apb(1'b1, 12'h008, 32'h0000_10ff);
        apb(1'b1, 12'h00c, 32'h0000_2000);
        apb(1'b1, 12'h010, 32'h0000_1fff);
        apb(1'b1, 12'h014, 32'h0000_0001);
        acc(2'd0, 32'h1000, 2'b10, 7'h0);
        expect_msg(6'h0e, 32'h1000, 2'b10, 7'h0);
        cpu_running <= 1'b1;
        acc(2'd0, 32'h1004, 2'b01, 7'h0);
        expect_msg(6'h06, 32'h1004, 2'b01, 7'h0);
        acc(2'd0, 32'h10ff, 2'b00, 7'h0);
        expect_msg(6'h06, 32'h10ff, 2'b00, 7'h0);
        acc(2'd0, 32'h1100, 2'b10, 7'h0);
        acc(2'd0, 32'h0fff, 2'b10, 7'h0);
        acc(2'd1, 32'h1008, 2'b10, 7'h0);
        none();
        apb(1'b1, 12'h000, 32'hd000_0000);
        acc(2'd0, 32'h2000, 2'b10, 7'h0);
        none();
        for (int op = 1; op < 4; op++) begin
            acc(2'd2, 32'h1010 + op, 2'b10, {5'(op + 4), 2'(op)});
            expect_msg(6'h3a, 32'h1010 + op, 2'b10, {5'(op + 4), 2'(op)});
        end
        ev(0);
        acc(2'd2, 32'h1020, 2'b10, {5'd31, 2'b10});
        expect_msg(6'h3b, 32'h1020, 2'b10, {5'd31, 2'b10});
        ev(1);
        acc(2'd0, 32'h1030, 2'b10, 7'h0);
        expect_msg(6'h0e, 32'h1030, 2'b10, 7'h0);
        apb(1'b1, 12'h014, 32'h0000_0003);
        ev(2);
        acc(2'd0, 32'h1040, 2'b10, 7'h0);
        expect_msg(6'h0e, 32'h1040, 2'b10, 7'h0);
        apb(1'b1, 12'h014, 32'h0000_0001);
        ev(2);
        acc(2'd0, 32'h1044, 2'b10, 7'h0);
        expect_msg(6'h06, 32'h1044, 2'b10, 7'h0);
        ev(3);
        acc(2'd0, 32'h1050, 2'b10, 7'h0);
        expect_msg(6'h08, 32'h0, 2'b00, 7'h0);
        expect_msg(6'h0e, 32'h1050, 2'b10, 7'h0);
        for (int i = 0; i < 255; i++) begin
            acc(2'd0, 32'h1000 + i, 2'b00, 7'h0);
            expect_msg(6'h06, 32'h1000 + i, 2'b00, 7'h0);
        end
        acc(2'd0, 32'h1060, 2'b10, 7'h0);
        expect_msg(6'h0e, 32'h1060, 2'b10, 7'h0);
        apb(1'b1, 12'h014, 32'h0000_0000);
        acc(2'd0, 32'h1064, 2'b10, 7'h0);
        none();
        ev(4);
        acc(2'd0, 32'h1068, 2'b10, 7'h0);
        expect_msg(6'h0e, 32'h1068, 2'b10, 7'h0);
        ev(5);
        acc(2'd0, 32'h106c, 2'b10, 7'h0);
        none();
        apb(1'b1, 12'h014, 32'h0000_0001);
        acc(2'd0, 32'h1070, 2'b10, 7'h0);
        expect_msg(6'h0e, 32'h1070, 2'b10, 7'h0);
        apb(1'b1, 12'h00c, 32'h0000_3000);
        apb(1'b1, 12'h010, 32'h0000_3000);
        apb(1'b1, 12'h000, 32'hd000_0003);
        acc(2'd0, 32'h3000, 2'b10, 7'h0);
        expect_msg(6'h06, 32'h3000, 2'b10, 7'h0);
        wpx(2'b10);
        acc(2'd0, 32'h3004, 2'b10, 7'h0);
        none();
        acc(2'd0, 32'h1000, 2'b10, 7'h0);
        expect_msg(6'h06, 32'h1000, 2'b10, 7'h0);
        wpx(2'b01);
        check(u_trace_tool.wps.size(), 0);
        complete_run();
    end
endmodule : tb_data_trace
